// ### hw/tpwm_defines.vh
// Purpose: shared constants of the 8-bit pwm timer
// Assumes: included by every tpwm design file
// Notes:   offsets are word indexes on the plain register port
`ifndef TPWM_DEFINES_VH
`define TPWM_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define TPWM_OFS_CTRL_A   8'h00
`define TPWM_OFS_CTRL_B   8'h01
`define TPWM_OFS_COUNT    8'h02
`define TPWM_OFS_CMP_A    8'h03
`define TPWM_OFS_CMP_B    8'h04
`define TPWM_OFS_FLAGS    8'h05
`define TPWM_OFS_DIR      8'h06
`define TPWM_OFS_PORT     8'h07
`define TPWM_OFS_STATE    8'h08

////////////////////////////////////////////////////////////////////////////////
// field positions
`define TPWM_COM_A_HI     7
`define TPWM_COM_A_LO     6
`define TPWM_COM_B_HI     5
`define TPWM_COM_B_LO     4
`define TPWM_WGM_HI_BIT   3
`define TPWM_CS_HI        2
`define TPWM_CS_LO        0
`define TPWM_FLG_OVF      0
`define TPWM_FLG_MA       1
`define TPWM_FLG_MB       2

////////////////////////////////////////////////////////////////////////////////
// reset values and fixed levels
`define TPWM_RST_BYTE     8'h00
`define TPWM_BOTTOM       8'h00
`define TPWM_MAX          8'hff
`define TPWM_WGM_FAST_FF  3'h3
`define TPWM_WGM_FAST_A   3'h7
`define TPWM_WGM_PC_FF    3'h1
`define TPWM_WGM_PC_A     3'h5

////////////////////////////////////////////////////////////////////////////////
// prescaler terminal counts (divide minus one)
`define TPWM_DIV1_LAST    10'h000
`define TPWM_DIV8_LAST    10'h007
`define TPWM_DIV64_LAST   10'h03f
`define TPWM_DIV256_LAST  10'h0ff
`define TPWM_DIV1024_LAST 10'h3ff

`endif

// ### hw/tpwm_prescaler.v
// Purpose: timer tick generator, one clk_sys pulse per prescaled period
// Assumes: sel 0 or 6..7 stops the tick
// Notes:   tick is registered and is used as a clock enable
`include "tpwm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tpwm_prescaler (
  input  wire       clk_sys, // system clock
  input  wire       resetn,  // async reset, active low
  input  wire [2:0] sel,     // prescale select
  output reg        tick_ff  // one-cycle timer tick
);

  reg  [9:0] pre_cnt_ff;
  reg  [9:0] last;
  reg        run;

  always @* begin
    run  = 1'b1;
    last = `TPWM_DIV1_LAST;
    case (sel)
      3'h1: last = `TPWM_DIV1_LAST;
      3'h2: last = `TPWM_DIV8_LAST;
      3'h3: last = `TPWM_DIV64_LAST;
      3'h4: last = `TPWM_DIV256_LAST;
      3'h5: last = `TPWM_DIV1024_LAST;
      default: run = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_ff <= 10'h000;
      tick_ff    <= 1'b0;
    end else begin
      tick_ff <= run && (pre_cnt_ff >= last);
      if (!run || pre_cnt_ff >= last)
        pre_cnt_ff <= 10'h000;
      else
        pre_cnt_ff <= pre_cnt_ff + 10'h001;
    end
  end

endmodule // tpwm_prescaler

`default_nettype wire

// ### hw/tpwm_out_unit.v
// Purpose: compare output state of one channel in both pwm modes
// Assumes: enables come from the counter logic on the same clock
// Notes:   oc_ff is the internal output state, not the pin
`include "tpwm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tpwm_out_unit (
  input  wire       clk_sys, // system clock
  input  wire       resetn,  // async reset, active low
  input  wire       tick,    // timer tick
  input  wire       blocked, // compare blocked after count write
  input  wire       fast,    // fast pwm mode
  input  wire       pc,      // phase correct mode
  input  wire       up,      // counting up
  input  wire       at_top,  // counter equals top
  input  wire       bottom,  // pc counter steps to bottom this tick
  input  wire [7:0] cnt,     // counter value
  input  wire [7:0] cmp,     // active compare value
  input  wire [7:0] top,     // active top
  input  wire [1:0] com,     // compare output mode
  input  wire       tog_en,  // toggle allowed on this channel
  output wire       match,   // unblocked compare match
  output reg        oc_ff    // output compare state
);

  reg  up_seen_ff;
  reg  nxt_oc;
  wire ign = com[1] && (cmp == top);

  assign match = tick && !blocked && (cnt == cmp);

  always @* begin
    nxt_oc = oc_ff;
    if (fast && tick) begin
      if (match && com[1] && !ign)
        nxt_oc = com[0];                                   // R03
      if (at_top && com[1])
        nxt_oc = ~com[0];                                  // R03 R04 R10 R24
      if (match && com == 2'b01 && tog_en)
        nxt_oc = ~oc_ff;                                   // R06
    end else if (pc && tick) begin
      if (match && com[1] && !ign)
        nxt_oc = up ? com[0] : ~com[0];                    // R15 R18
      if (at_top && ign)
        nxt_oc = ~com[0];                                  // R24
      if (bottom && com[1] && !ign && !up_seen_ff)
        nxt_oc = com[0];                                   // R19 R20
      if (match && com == 2'b01 && tog_en)
        nxt_oc = ~oc_ff;                                   // R06
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oc_ff      <= 1'b0;                                  // R25
      up_seen_ff <= 1'b0;
    end else begin
      oc_ff <= nxt_oc;
      if (tick && bottom)
        up_seen_ff <= 1'b0;
      // an ignored match at top is no up-count match
      else if (match && up && !ign)
        up_seen_ff <= 1'b1;
    end
  end

endmodule // tpwm_out_unit

`default_nettype wire

// ### hw/tpwm_top.v
// Purpose: 8-bit timer waveform generator, fast and phase correct pwm
// Assumes: register port on clk_sys, strobes one cycle, never together
// Notes:   read data valid in the cycle after the read strobe only
//
// Functional notes
// R01: mode selector 3 or 7 runs single-slope fast pwm
// R02: fast pwm top is 0xff in mode 3, compare a in mode 7
// R03: fast pwm com 2 clears on match sets at bottom; com 3 inverse
// R04: fast counter reaches top then clears to bottom on next tick
// R05: fast pwm sets overflow flag whenever counter reaches top
// R06: com 1 on channel a toggles on match only with mode high bit
// R07: pin driven only when its direction bit selects output
// R08: fixed top 0xff gives a fast period of 256 ticks
// R09: tick prescale selectable as 1, 8, 64, 256 or 1024
// R10: fast compare bottom gives spike, compare max gives constant level
// R11: compare writes double buffered, applied at the update point
// R12: mode selector 1 or 5 runs dual-slope phase correct pwm
// R13: phase correct top is 0xff in mode 1, compare a in mode 5
// R14: phase correct counter counts down from top on the next tick, no hold
// R15: non-inverting clears on up match, sets on down match; inverting opposite
// R16: phase correct sets overflow flag whenever counter reaches bottom
// R17: fixed top 0xff gives a phase correct period of 510 ticks
// R18: phase correct compare bottom holds low, max holds high, inverted opposite
// R19: leaving max forces the up-count result at bottom for symmetry
// R20: a missed up-count match is applied at bottom for symmetry
// R21: fully synchronous, tick acts as clock enable for all actions
// R22: com 0 does nothing on match and leaves pin to port
// R23: a counter write blocks compare matches in the following tick
// R24: compare equal top with com high bit ignores match, acts at boundary
// R25: counter, output states and overflow flag reset to zero
`include "tpwm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tpwm_top (
  input  wire       clk_sys,     // system clock, 40 MHz
  input  wire       resetn,      // async reset, active low
  input  wire [7:0] reg_addr,    // register index
  input  wire [7:0] reg_wdata,   // write data
  input  wire       reg_wr,      // write strobe
  input  wire       reg_rd,      // read strobe
  output reg  [7:0] reg_rdata_ff, // read data, cycle after strobe
  output reg        pin_a_out_ff, // compare a pin value
  output reg        pin_a_oe_ff,  // compare a pin output enable
  output reg        pin_b_out_ff, // compare b pin value
  output reg        pin_b_oe_ff   // compare b pin output enable
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0] ctrl_a_ff;
  reg  [7:0] ctrl_b_ff;
  reg  [7:0] count_value_ff;
  reg  [7:0] cmp_a_buf_ff;
  reg  [7:0] cmp_b_buf_ff;
  reg  [7:0] compare_value_a_ff;
  reg  [7:0] compare_value_b_ff;

  reg        overflow_flag_ff;
  reg        match_flag_a_ff;
  reg        match_flag_b_ff;

  reg  [1:0] dir_ff;
  reg  [1:0] port_ff;
  reg        up_ff;
  reg        block_ff;

  // next counter state and events of the coming tick
  reg  [7:0] nxt_count;
  reg        nxt_up;
  reg        bottom;
  reg        reach_evt;

  // prescaler tick and unblocked matches of both channels
  wire       timer_tick;
  wire       match_a;
  wire       match_b;
  wire       compare_out_a;
  wire       compare_out_b;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  wire [2:0] waveform_mode_sel = {ctrl_b_ff[`TPWM_WGM_HI_BIT], ctrl_a_ff[1:0]};
  wire       waveform_mode_hi_bit = ctrl_b_ff[`TPWM_WGM_HI_BIT];
  wire [1:0] compare_out_mode_a = ctrl_a_ff[`TPWM_COM_A_HI:`TPWM_COM_A_LO];
  wire [1:0] compare_out_mode_b = ctrl_a_ff[`TPWM_COM_B_HI:`TPWM_COM_B_LO];

  // other mode values only count up, no compare output action
  wire fast = (waveform_mode_sel == `TPWM_WGM_FAST_FF) ||
              (waveform_mode_sel == `TPWM_WGM_FAST_A);    // R01
  wire pc   = (waveform_mode_sel == `TPWM_WGM_PC_FF) ||
              (waveform_mode_sel == `TPWM_WGM_PC_A);      // R12
  wire pwm  = fast || pc;

  // top from compare a whenever the mode high bit is set, otherwise the fixed max
  wire [7:0] top = waveform_mode_hi_bit ? compare_value_a_ff
                                        : `TPWM_MAX;      // R02 R13
  wire at_top = (count_value_ff == top);

  // count write beats a tick in the same cycle and arms the blocker
  wire wr_count = reg_wr && (reg_addr == `TPWM_OFS_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  // tick is registered, so a new prescale acts a cycle later
  tpwm_prescaler u_pre (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sel     (ctrl_b_ff[`TPWM_CS_HI:`TPWM_CS_LO]),       // R09
    .tick_ff (timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter sequence

  // fast wraps at top; phase correct turns at top and bottom without a hold
  always @* begin
    nxt_count = count_value_ff;
    nxt_up    = up_ff;
    bottom    = 1'b0;
    reach_evt = 1'b0;
    if (fast) begin
      nxt_up = 1'b1;
      if (at_top)
        nxt_count = `TPWM_BOTTOM;                          // R04 R08
      else
        nxt_count = count_value_ff + 8'h01;
      reach_evt = (nxt_count == top);                      // R05
    end else if (pc) begin
      if (up_ff) begin
        if (at_top) begin
          nxt_up    = 1'b0;                                // R14
          nxt_count = count_value_ff - 8'h01;
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
      end else begin
        if (count_value_ff == `TPWM_BOTTOM) begin
          nxt_up    = 1'b1;
          nxt_count = count_value_ff + 8'h01;
        end else begin
          nxt_count = count_value_ff - 8'h01;
          if (nxt_count == `TPWM_BOTTOM) begin
            nxt_up = 1'b1;                                 // R17
            bottom = 1'b1;
          end
        end
      end
      reach_evt = bottom;                                  // R16
    end else begin
      nxt_up    = 1'b1;
      nxt_count = count_value_ff + 8'h01;
      reach_evt = (nxt_count == `TPWM_BOTTOM);
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_value_ff <= `TPWM_RST_BYTE;                    // R25
      up_ff          <= 1'b1;
      block_ff       <= 1'b0;
    end else begin
      if (wr_count) begin
        count_value_ff <= reg_wdata;
        block_ff       <= 1'b1;                            // R23
      end else if (timer_tick) begin
        count_value_ff <= nxt_count;                       // R21
        up_ff          <= nxt_up;
        block_ff       <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare double buffering

  // fast mode loads at the wrap to bottom, phase correct at top
  wire load_fast = fast && at_top;
  wire load_pc   = pc && up_ff && at_top;

  // outside pwm the buffers pass straight through
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      compare_value_a_ff <= `TPWM_RST_BYTE;
      compare_value_b_ff <= `TPWM_RST_BYTE;
    end else if (!pwm || (timer_tick && (load_fast || load_pc))) begin
      compare_value_a_ff <= cmp_a_buf_ff;                  // R11
      compare_value_b_ff <= cmp_b_buf_ff;                  // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare output units

  // channel a toggles on com 1 only with the mode high bit
  tpwm_out_unit u_out_a (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tick    (timer_tick),
    .blocked (block_ff),
    .fast    (fast),
    .pc      (pc),
    .up      (up_ff),
    .at_top  (at_top),
    .bottom  (bottom),
    .cnt     (count_value_ff),
    .cmp     (compare_value_a_ff),
    .top     (top),
    .com     (compare_out_mode_a),
    .tog_en  (waveform_mode_hi_bit),                       // R06
    .match   (match_a),
    .oc_ff   (compare_out_a)
  );

  // channel b never toggles
  tpwm_out_unit u_out_b (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tick    (timer_tick),
    .blocked (block_ff),
    .fast    (fast),
    .pc      (pc),
    .up      (up_ff),
    .at_top  (at_top),
    .bottom  (bottom),
    .cnt     (count_value_ff),
    .cmp     (compare_value_b_ff),
    .top     (top),
    .com     (compare_out_mode_b),
    .tog_en  (1'b0),                                       // R06
    .match   (match_b),
    .oc_ff   (compare_out_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin override

  // com 1 on channel a is only connected with the mode high bit in pwm
  wire conn_a = compare_out_mode_a[1] ||
                (compare_out_mode_a[0] && (waveform_mode_hi_bit || !pwm));

  wire conn_b = compare_out_mode_b[1] || (compare_out_mode_b[0] && !pwm);

  // every pin output leaves a flip-flop
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_a_out_ff <= 1'b0;
      pin_a_oe_ff  <= 1'b0;
      pin_b_out_ff <= 1'b0;
      pin_b_oe_ff  <= 1'b0;
    end else begin
      pin_a_out_ff <= conn_a ? compare_out_a : port_ff[0]; // R22
      pin_b_out_ff <= conn_b ? compare_out_b : port_ff[1]; // R22
      pin_a_oe_ff  <= dir_ff[0];                           // R07
      pin_b_oe_ff  <= dir_ff[1];                           // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, set wins over a write-one clear

  // flags ignore the tick that a count write overrides
  wire wr_flags = reg_wr && (reg_addr == `TPWM_OFS_FLAGS);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overflow_flag_ff <= 1'b0;                            // R25
      match_flag_a_ff  <= 1'b0;
      match_flag_b_ff  <= 1'b0;
    end else begin
      if (timer_tick && reach_evt && !wr_count)
        overflow_flag_ff <= 1'b1;                          // R05 R16
      else if (wr_flags && reg_wdata[`TPWM_FLG_OVF])
        overflow_flag_ff <= 1'b0;

      if (match_a && !wr_count)
        match_flag_a_ff <= 1'b1;
      else if (wr_flags && reg_wdata[`TPWM_FLG_MA])
        match_flag_a_ff <= 1'b0;

      if (match_b && !wr_count)
        match_flag_b_ff <= 1'b1;
      else if (wr_flags && reg_wdata[`TPWM_FLG_MB])
        match_flag_b_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // reserved control bits are stored as zero and read back as zero
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_ff    <= `TPWM_RST_BYTE;
      ctrl_b_ff    <= `TPWM_RST_BYTE;
      cmp_a_buf_ff <= `TPWM_RST_BYTE;
      cmp_b_buf_ff <= `TPWM_RST_BYTE;
      dir_ff       <= 2'b00;
      port_ff      <= 2'b00;
    end else if (reg_wr) begin
      case (reg_addr)
        `TPWM_OFS_CTRL_A: ctrl_a_ff    <= reg_wdata & 8'hf3;
        `TPWM_OFS_CTRL_B: ctrl_b_ff    <= reg_wdata & 8'h0f;
        `TPWM_OFS_CMP_A:  cmp_a_buf_ff <= reg_wdata;
        `TPWM_OFS_CMP_B:  cmp_b_buf_ff <= reg_wdata;
        `TPWM_OFS_DIR:    dir_ff       <= reg_wdata[1:0];
        `TPWM_OFS_PORT:   port_ff      <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  // read data return to zero outside the answer cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TPWM_OFS_CTRL_A: reg_rdata_ff <= ctrl_a_ff;
        `TPWM_OFS_CTRL_B: reg_rdata_ff <= ctrl_b_ff;
        `TPWM_OFS_COUNT:  reg_rdata_ff <= count_value_ff;
        `TPWM_OFS_CMP_A:  reg_rdata_ff <= cmp_a_buf_ff;
        `TPWM_OFS_CMP_B:  reg_rdata_ff <= cmp_b_buf_ff;
        `TPWM_OFS_FLAGS:  reg_rdata_ff <= {5'h00, match_flag_b_ff,
                                           match_flag_a_ff, overflow_flag_ff};
        `TPWM_OFS_DIR:    reg_rdata_ff <= {6'h00, dir_ff};
        `TPWM_OFS_PORT:   reg_rdata_ff <= {6'h00, port_ff};
        `TPWM_OFS_STATE:  reg_rdata_ff <= {5'h00, up_ff,
                                           compare_out_b, compare_out_a};
        default:          reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

endmodule // tpwm_top

`default_nettype wire

// ### dv/tpwm_top_sva.sv
// Purpose: port checker for tpwm_top
// Assumes: one clock domain, clk_sys
// Notes:   shadows of ctrl, dir and port follow register writes
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defines.vh"
module tpwm_chk (
  input wire logic       clk_sys,      // system clock
  input wire logic       resetn,       // async reset, active low
  input wire logic [7:0] reg_addr,     // register index
  input wire logic [7:0] reg_wdata,    // write data
  input wire logic       reg_wr,       // write strobe
  input wire logic       reg_rd,       // read strobe
  input wire logic [7:0] reg_rdata_ff, // read data
  input wire logic       pin_a_out_ff, // pin a value
  input wire logic       pin_a_oe_ff,  // pin a enable
  input wire logic       pin_b_out_ff, // pin b value
  input wire logic       pin_b_oe_ff   // pin b enable
);
  logic [7:0] ctl_a_ff;
  logic       hi_ff;
  logic [1:0] dir_ff;
  logic [1:0] port_ff;
  logic       disc_a;
  logic       disc_b;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_a_ff <= 8'h00;
      hi_ff    <= 1'b0;
      dir_ff   <= 2'h0;
      port_ff  <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == `TPWM_OFS_CTRL_A) ctl_a_ff <= reg_wdata;
      if (reg_addr == `TPWM_OFS_CTRL_B) hi_ff <= reg_wdata[3];
      if (reg_addr == `TPWM_OFS_DIR) dir_ff <= reg_wdata[1:0];
      if (reg_addr == `TPWM_OFS_PORT) port_ff <= reg_wdata[1:0];
    end
  end
  // pin left to the port: com 0, or com 1 where pwm gives no toggle
  assign disc_a = ctl_a_ff[7:6] == 2'h0 || (ctl_a_ff[7:6] == 2'h1 && !hi_ff && ctl_a_ff[0]);
  assign disc_b = ctl_a_ff[5:4] == 2'h0 || (ctl_a_ff[5:4] == 2'h1 && ctl_a_ff[0]);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |->
    {pin_a_out_ff, pin_a_oe_ff, pin_b_out_ff, pin_b_oe_ff, reg_rdata_ff} == 12'h000)
    else $error("outputs not quiet in reset");
  a_oe_dir: assert property ({pin_b_oe_ff, pin_a_oe_ff} == $past(dir_ff))
    else $error("output enable differs from direction");
  a_a_port: assert property ($past(disc_a) |-> pin_a_out_ff == $past(port_ff[0]))
    else $error("pin a not given to port");
  a_b_port: assert property ($past(disc_b) |-> pin_b_out_ff == $past(port_ff[1]))
    else $error("pin b not given to port");
  a_rdata_pulse: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data outside its cycle");
  a_dir_read: assert property ($past(reg_rd && reg_addr == `TPWM_OFS_DIR) |->
    reg_rdata_ff == {6'h00, $past(dir_ff)}) else $error("direction readback wrong");
  a_ctrl_read: assert property ($past(reg_rd && reg_addr == `TPWM_OFS_CTRL_A) |->
    reg_rdata_ff == ($past(ctl_a_ff) & 8'hf3)) else $error("control a readback wrong");
  a_unmapped_read: assert property ($past(reg_rd && reg_addr > `TPWM_OFS_STATE) |->
    reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
  c_read: cover property (reg_rd ##1 reg_rdata_ff != 8'h00);
  c_pin_a: cover property (pin_a_oe_ff && $rose(pin_a_out_ff));
  c_pin_b: cover property (pin_b_oe_ff && $fell(pin_b_out_ff));
endmodule // tpwm_chk
bind tpwm_top tpwm_chk u_tpwm_chk (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_ff, .pin_a_out_ff, .pin_a_oe_ff, .pin_b_out_ff, .pin_b_oe_ff);
`default_nettype wire

// ### dv/tpwm_top_tb.sv
// Purpose: self-checking bench of tpwm_top
// Assumes: 40 MHz clk_sys, register port strobes one cycle
// Notes:   pin times are counted in clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defines.vh"
module tpwm_top_tb;
  typedef struct packed {
    logic [7:0]  ca, cb, ma, mb;
    logic        ch;
    logic [15:0] hi, per;
  } tpwm_case_t;
  logic       clk_sys   = 1'b0;
  logic       resetn    = 1'b1;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  wire  [7:0] reg_rdata_ff;
  wire        pin_a_out_ff, pin_a_oe_ff, pin_b_out_ff, pin_b_oe_ff;
  int         n_errors = 0;
  int         n_tests  = 0;
  int         cyc      = 0;
  int         hi, per, n;
  logic [7:0] d;
  // ctrl a, ctrl b, cmp a, cmp b, channel, high cycles, period cycles
  tpwm_case_t rows [14] = '{
    '{8'h83, 8'h01, 8'h40, 8'h00, 1'b0, 16'h0041, 16'h0100},
    '{8'hc3, 8'h01, 8'h40, 8'h00, 1'b0, 16'h00bf, 16'h0100},
    '{8'h83, 8'h01, 8'h00, 8'h00, 1'b0, 16'h0001, 16'h0100},
    '{8'h23, 8'h09, 8'h3f, 8'h10, 1'b1, 16'h0011, 16'h0040},
    '{8'h63, 8'h09, 8'h3f, 8'h00, 1'b0, 16'h0040, 16'h0080},
    '{8'h81, 8'h01, 8'h40, 8'h00, 1'b0, 16'h0080, 16'h01fe},
    '{8'hc1, 8'h01, 8'h40, 8'h00, 1'b0, 16'h017e, 16'h01fe},
    '{8'h21, 8'h09, 8'h3f, 8'h10, 1'b1, 16'h0020, 16'h007e},
    '{8'h61, 8'h09, 8'h3f, 8'h00, 1'b0, 16'h007e, 16'h00fc},
    '{8'h23, 8'h09, 8'h03, 8'h01, 1'b1, 16'h0002, 16'h0004},
    '{8'h23, 8'h0a, 8'h03, 8'h01, 1'b1, 16'h0010, 16'h0020},
    '{8'h23, 8'h0b, 8'h03, 8'h01, 1'b1, 16'h0080, 16'h0100},
    '{8'h23, 8'h0c, 8'h03, 8'h01, 1'b1, 16'h0200, 16'h0400},
    '{8'h23, 8'h0d, 8'h03, 8'h01, 1'b1, 16'h0800, 16'h1000}};
  tpwm_top u_tpwm_top (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .pin_a_out_ff, .pin_a_oe_ff, .pin_b_out_ff, .pin_b_oe_ff);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkn(input string nm, input int e, input int g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_ff;
  endtask
  // stop, load compares in pass-through mode, then start
  task automatic cfg(input logic [7:0] ca, cb, ma, mb);
    wr(`TPWM_OFS_CTRL_B, 8'h00);
    wr(`TPWM_OFS_CTRL_A, 8'h00);
    wr(`TPWM_OFS_CMP_A, ma);
    wr(`TPWM_OFS_CMP_B, mb);
    wr(`TPWM_OFS_COUNT, 8'h00);
    wr(`TPWM_OFS_DIR, 8'h03);
    wr(`TPWM_OFS_CTRL_A, ca);
    wr(`TPWM_OFS_CTRL_B, cb);
  endtask
  task automatic lvl(input logic b, input logic v, output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while ((b ? pin_b_out_ff : pin_a_out_ff) !== v && k < 20000);
  endtask
  task automatic meas(input logic b);
    lvl(b, 1'b0, n);
    lvl(b, 1'b1, n);
    lvl(b, 1'b0, hi);
    lvl(b, 1'b1, n);
    per = hi + n;
  endtask
  task automatic steady(input logic b, input logic v);
    repeat (600) @(posedge clk_sys);
    n = 0;
    repeat (600) begin
      @(posedge clk_sys);
      #1 if ((b ? pin_b_out_ff : pin_a_out_ff) !== v) n++;
    end
    chkn("cycles off steady level", 0, n);
  endtask
  task automatic ovf(input int k);
    wr(`TPWM_OFS_FLAGS, 8'h01);
    repeat (k) @(posedge clk_sys);
    rd(`TPWM_OFS_FLAGS, d);
    chk8("overflow flag", 8'h01, d & 8'h01);
  endtask
  task automatic rst_chk;
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk8("pins in reset", 8'h00, {4'h0, pin_a_out_ff, pin_a_oe_ff, pin_b_out_ff, pin_b_oe_ff});
    @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i), d);
      chk8("register after reset", 8'h00, d);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst_chk();
    foreach (rows[i]) begin
      cfg(rows[i].ca, rows[i].cb, rows[i].ma, rows[i].mb);
      meas(rows[i].ch);
      meas(rows[i].ch);
      chkn("high time", rows[i].hi, hi);
      chkn("period", rows[i].per, per);
    end
    cfg(8'h00, 8'h00, 8'h00, 8'h00);
    wr(`TPWM_OFS_CTRL_A, 8'hff);
    rd(`TPWM_OFS_CTRL_A, d);
    chk8("control a", 8'hf3, d);
    wr(`TPWM_OFS_CTRL_B, 8'hf8);
    rd(`TPWM_OFS_CTRL_B, d);
    chk8("control b", 8'h08, d);
    wr(`TPWM_OFS_COUNT, 8'h37);
    rd(`TPWM_OFS_COUNT, d);
    chk8("stopped count", 8'h37, d);
    wr(8'h20, 8'hff);
    rd(8'h20, d);
    chk8("unmapped", 8'h00, d);
    cfg(8'h83, 8'h00, 8'h37, 8'h00);
    wr(`TPWM_OFS_FLAGS, 8'h07);
    wr(`TPWM_OFS_COUNT, 8'h37);
    wr(`TPWM_OFS_CTRL_B, 8'h01);
    repeat (4) @(posedge clk_sys);
    rd(`TPWM_OFS_FLAGS, d);
    chk8("match after count write", 8'h00, d & 8'h02);
    cfg(8'h83, 8'h01, 8'h40, 8'h00);
    meas(1'b0);
    lvl(1'b0, 1'b1, n);
    wr(`TPWM_OFS_CMP_A, 8'h80);
    lvl(1'b0, 1'b0, n);
    chkn("high before update", 65, n + 3);
    meas(1'b0);
    chkn("high after update", 129, hi);
    ovf(300);
    cfg(8'h81, 8'h01, 8'h40, 8'h00);
    ovf(600);
    cfg(8'h81, 8'h01, 8'h00, 8'h00);
    steady(1'b0, 1'b0);
    cfg(8'h81, 8'h01, 8'hff, 8'h00);
    steady(1'b0, 1'b1);
    wr(`TPWM_OFS_CMP_A, 8'h40);
    lvl(1'b0, 1'b0, n);
    rd(`TPWM_OFS_COUNT, d);
    chk8("count at symmetry fall", 8'h02, d);
    cfg(8'hc1, 8'h01, 8'hff, 8'h00);
    steady(1'b0, 1'b0);
    cfg(8'h83, 8'h01, 8'hff, 8'h00);
    steady(1'b0, 1'b1);
    cfg(8'h53, 8'h01, 8'h40, 8'h40);
    wr(`TPWM_OFS_PORT, 8'h03);
    steady(1'b0, 1'b1);
    steady(1'b1, 1'b1);
    cfg(8'h03, 8'h01, 8'h40, 8'h40);
    steady(1'b0, 1'b1);
    wr(`TPWM_OFS_DIR, 8'h00);
    @(posedge clk_sys);
    #1 chk8("output enables", 8'h00, {6'h00, pin_b_oe_ff, pin_a_oe_ff});
    cfg(8'h83, 8'h01, 8'h40, 8'h00);
    repeat (100) @(posedge clk_sys);
    rst_chk();
    test_done();
  end
endmodule // tpwm_top_tb
`default_nettype wire
